//--- core/touch_proximity_calibration.v
// Proximity detection and ambient calibration control for one sensor stage.
// Assumes conversion results arrive on one clock with a valid pulse, and an
// end-of-sequence pulse per completed conversion sequence.
`include "touch_proximity_map.vh"

module touch_proximity_calibration #(
  parameter DW = 16
) (
  input  wire          clock,           // 125 MHz system clock
  input  wire          resetn,          // Asynchronous reset, active low
  input  wire [7:0]    reg_addr,        // Register word address
  input  wire [15:0]   reg_wdata,       // Register write data
  input  wire          reg_wr,          // Write strobe
  input  wire          reg_rd,          // Read strobe
  output reg  [15:0]   reg_rdata,       // Read data, one cycle after strobe
  input  wire          conv_valid,      // Conversion result valid pulse
  input  wire [DW-1:0] conv_data,       // Conversion result
  input  wire          seq_done,        // Conversion sequence complete pulse
  input  wire          low_power,       // Low power mode level
  output wire          int_n,           // Touch interrupt, active low
  output reg           cal_enabled,     // Ambient calibration currently enabled
  output reg           proximity        // Proximity indication
);

  reg  [15:0]   hold_skip_q;
  reg  [15:0]   level_q;
  reg  [15:0]   recal_q;
  reg  [15:0]   sens_q;
  reg  [15:0]   offsets_q;
  reg  [DW-1:0] ff_q [0:3];
  reg  [DW-1:0] sf0_q;
  reg  [DW-1:0] sf1_q;
  reg  [DW-1:0] ambient_q;
  reg  [3:0]    skip_cnt_q;
  reg  [13:0]   hold_cnt_q;
  reg           holding_q;
  reg  [9:0]    recal_cnt_q;
  reg           recal_pend_q;
  reg  [1:0]    recal_ph_q;
  reg           touch_q;
  reg           touch_high_q;
  reg           touch_low_q;
  integer       i;
  integer       j;

  wire [3:0]  skip_cnt   = hold_skip_q[`SKIP_MSB:`SKIP_LSB];
  wire [3:0]  fp_hold    = hold_skip_q[`FP_HOLD_MSB:`FP_HOLD_LSB];
  wire [3:0]  lp_hold    = hold_skip_q[`LP_HOLD_MSB:`LP_HOLD_LSB];
  wire [7:0]  det_rate   = level_q[`RATE_MSB:`RATE_LSB];
  wire [5:0]  recal_lvl  = level_q[`RECAL_LVL_MSB:`RECAL_LVL_LSB];
  wire [1:0]  sf_lvl     = level_q[`SF_LVL_MSB:`SF_LVL_LSB];
  wire [9:0]  fp_recal   = recal_q[`FP_RECAL_MSB:`FP_RECAL_LSB];
  wire [5:0]  lp_recal   = recal_q[`LP_RECAL_MSB:`LP_RECAL_LSB];

  function [DW-1:0] absdiff;
    input [DW-1:0] a;
    input [DW-1:0] b;
    begin
      absdiff = (a > b) ? a - b : b - a;
    end
  endfunction

  // Sensitivity fraction in 1/64: 16 steps from 16/64 (25 %) to 61/64 (95.3 %)
  function [DW-1:0] scale;
    input [7:0] off;
    input [3:0] sel;
    reg   [15:0] prod;
    begin
      prod  = off * ({2'h0, sel} * 6'h03 + 6'h10);
      scale = {{(DW-10){1'b0}}, prod[15:6]};
    end
  endfunction

  // Hold-off multipliers at the width of the hold-off counter
  localparam [13:0] FP_MULT = `FP_HOLD_MULT;
  localparam [13:0] LP_MULT = `LP_HOLD_MULT;

  // Address decode for the register port
  wire          wr_hold_skip = reg_wr && (reg_addr == `HOLD_SKIP_OFFSET);
  wire          wr_level     = reg_wr && (reg_addr == `LEVEL_OFFSET);
  wire          wr_recal     = reg_wr && (reg_addr == `RECAL_OFFSET);
  wire          wr_sens      = reg_wr && (reg_addr == `SENS_OFFSET);
  wire          wr_offsets   = reg_wr && (reg_addr == `MODE_OFFSET);

  // Fast FIFO average and the three comparator distances
  wire [DW+1:0] ff_sum    = ff_q[0] + ff_q[1] + ff_q[2] + ff_q[3];
  wire [DW-1:0] ff_avg    = ff_sum[DW+1:2];
  wire [DW-1:0] ff_delta  = absdiff(ff_q[0], ff_q[3]);
  wire [DW-1:0] avg_delta = absdiff(ff_avg, ambient_q);
  wire [DW-1:0] sf_delta  = absdiff(sf0_q, sf1_q);
  wire          prox1     = ff_delta > {{(DW-8){1'b0}}, det_rate};
  wire          prox2     = avg_delta > {{(DW-6){1'b0}}, recal_lvl};
  wire          prox_now  = prox1 | prox2;
  wire          sf_enable = sf_delta > {{(DW-2){1'b0}}, sf_lvl};

  // Threshold distances; both thresholds saturate instead of wrapping
  wire [DW-1:0] pos_step  = scale(offsets_q[7:0], sens_q[3:0]);
  wire [DW-1:0] neg_step  = scale(offsets_q[15:8], sens_q[7:4]);
  wire [DW:0]   hi_sum    = {1'b0, ambient_q} + {1'b0, pos_step};
  wire [DW-1:0] hi_thr    = hi_sum[DW] ? {DW{1'b1}} : hi_sum[DW-1:0];
  wire [DW-1:0] lo_thr    = (ambient_q >= neg_step) ? ambient_q - neg_step
                                                    : {DW{1'b0}};
  wire          over_hi   = conv_data > hi_thr;
  wire          under_lo  = conv_data < lo_thr;

  // Timing lengths, counted in completed sequences
  wire          above_lvl = (conv_data > ambient_q) &&
                            (conv_data - ambient_q > {{(DW-6){1'b0}}, recal_lvl});
  wire [13:0]   hold_len  = low_power ? {10'h000, lp_hold} * LP_MULT
                                      : {10'h000, fp_hold} * FP_MULT;
  wire [9:0]    recal_len = low_power ? {4'h0, lp_recal} : fp_recal;
  wire          ff_push   = conv_valid && (skip_cnt_q >= skip_cnt);
  wire          recal_go  = recal_pend_q && recal_ph_q == 2'h0;
  wire          recal_due = above_lvl && proximity && seq_done && !recal_pend_q &&
                            (recal_cnt_q + 10'h001 >= recal_len);
  wire          amb_track = conv_valid && sf_enable && !proximity &&
                            cal_enabled && !touch_q;

  assign int_n = ~(touch_high_q | touch_low_q);

  // Hold-off and skip control; bits 15:12 are not kept
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hold_skip_q <= `HOLD_SKIP_RESET;
    end else if (wr_hold_skip) begin
      hold_skip_q <= {4'h0, reg_wdata[11:0]};
    end
  end

  // Detection rate, recalibration level and slow update level
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      level_q <= `LEVEL_RESET;
    end else if (wr_level) begin
      level_q <= reg_wdata;
    end
  end

  // Recalibration timeout counts
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      recal_q <= `RECAL_RESET;
    end else if (wr_recal) begin
      recal_q <= reg_wdata;
    end
  end

  // Sensitivity selects; bits 15:8 are not kept
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sens_q <= `SENS_RESET;
    end else if (wr_sens) begin
      sens_q <= {8'h00, reg_wdata[7:0]};
    end
  end

  // High and low threshold offsets
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      offsets_q <= `MODE_RESET;
    end else if (wr_offsets) begin
      offsets_q <= reg_wdata;
    end
  end

  // Read data stand for the one cycle after the strobe, zero otherwise
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `HOLD_SKIP_OFFSET: reg_rdata <= hold_skip_q;
        `LEVEL_OFFSET:     reg_rdata <= level_q;
        `RECAL_OFFSET:     reg_rdata <= recal_q;
        `SENS_OFFSET:      reg_rdata <= sens_q;
        `MODE_OFFSET:      reg_rdata <= offsets_q;
        `STATUS_OFFSET:    reg_rdata <= {10'h000, recal_pend_q, holding_q, touch_low_q,
                                         touch_high_q, cal_enabled, proximity};
        `AMBIENT_OFFSET:   reg_rdata <= ambient_q[15:0];
        default:           reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // Skip counter; a lowered skip count takes effect on the next result
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      skip_cnt_q <= 4'h0;
    end else if (conv_valid) begin
      skip_cnt_q <= ff_push ? 4'h0 : skip_cnt_q + 4'h1;
    end
  end

  // Fast FIFO, newest word in slot 0
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      for (i = 0; i < 4; i = i + 1) begin
        ff_q[i] <= {DW{1'b0}};
      end
    end else if (ff_push) begin
      ff_q[0] <= conv_data;
      for (j = 1; j < 4; j = j + 1) begin
        ff_q[j] <= ff_q[j-1];
      end
    end
  end

  // Slow FIFO; a forced recalibration reloads its older word
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sf0_q <= {DW{1'b0}};
      sf1_q <= {DW{1'b0}};
    end else begin
      if (conv_valid) begin
        sf0_q <= conv_data;
      end
      if (recal_go) begin
        sf1_q <= ff_avg;
      end else if (amb_track) begin
        sf1_q <= sf0_q;
      end
    end
  end

  // Ambient level
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ambient_q <= {DW{1'b0}};
    end else if (recal_go) begin
      ambient_q <= ff_avg;
    end else if (amb_track) begin
      ambient_q <= sf0_q;
    end
  end

  // Registered proximity indication
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      proximity <= 1'b0;
    end else begin
      proximity <= prox_now;
    end
  end

  // Calibration freeze and hold-off after proximity clears
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cal_enabled <= 1'b1;
      holding_q   <= 1'b0;
      hold_cnt_q  <= 14'h0000;
    end else if (prox_now) begin
      cal_enabled <= 1'b0;
      holding_q   <= 1'b0;
      hold_cnt_q  <= 14'h0000;
    end else if (proximity) begin
      holding_q  <= 1'b1;
      hold_cnt_q <= 14'h0000;
    end else if (holding_q && seq_done) begin
      if (hold_cnt_q + 14'h0001 >= hold_len) begin
        holding_q   <= 1'b0;
        cal_enabled <= !touch_q;
        hold_cnt_q  <= 14'h0000;
      end else begin
        hold_cnt_q <= hold_cnt_q + 14'h0001;
      end
    end else if (!holding_q && !cal_enabled && !touch_q) begin
      cal_enabled <= 1'b1;
    end
  end

  // Recalibration timeout, restarted whenever the hover condition drops
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      recal_cnt_q <= 10'h000;
    end else if (!above_lvl || !proximity) begin
      recal_cnt_q <= 10'h000;
    end else if (seq_done && !recal_pend_q) begin
      recal_cnt_q <= recal_due ? 10'h000 : recal_cnt_q + 10'h001;
    end
  end

  // Recalibration spans two sequences before another may start
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      recal_pend_q <= 1'b0;
      recal_ph_q   <= 2'h0;
    end else if (recal_due) begin
      recal_pend_q <= 1'b1;
    end else if (recal_pend_q && seq_done) begin
      if (recal_ph_q == 2'h1) begin
        recal_pend_q <= 1'b0;
        recal_ph_q   <= 2'h0;
      end else begin
        recal_ph_q <= recal_ph_q + 2'h1;
      end
    end else if (recal_go) begin
      recal_ph_q <= 2'h0;
    end
  end

  // Contact detection against both thresholds
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      touch_high_q <= 1'b0;
      touch_low_q  <= 1'b0;
      touch_q      <= 1'b0;
    end else if (conv_valid) begin
      touch_high_q <= over_hi;
      touch_low_q  <= under_lo;
      touch_q      <= over_hi | under_lo;
    end
  end

endmodule

//--- core/touch_proximity_map.vh
// Register offsets, field positions and reset values for the proximity
// and ambient calibration block. Included by the design; definitions only.
`ifndef TOUCH_PROXIMITY_MAP_VH
`define TOUCH_PROXIMITY_MAP_VH

`define HOLD_SKIP_OFFSET    8'h02
`define LEVEL_OFFSET        8'h03
`define RECAL_OFFSET        8'h04
`define SENS_OFFSET         8'h05
`define MODE_OFFSET         8'h06
`define STATUS_OFFSET       8'h07
`define AMBIENT_OFFSET      8'h08

`define SKIP_LSB            0
`define SKIP_MSB            3
`define FP_HOLD_LSB         4
`define FP_HOLD_MSB         7
`define LP_HOLD_LSB         8
`define LP_HOLD_MSB         11
`define RATE_LSB            0
`define RATE_MSB            7
`define RECAL_LVL_LSB       8
`define RECAL_LVL_MSB       13
`define SF_LVL_LSB          14
`define SF_LVL_MSB          15
`define FP_RECAL_LSB        0
`define FP_RECAL_MSB        9
`define LP_RECAL_LSB        10
`define LP_RECAL_MSB        15

`define HOLD_SKIP_RESET     16'h0000
`define LEVEL_RESET         16'h0000
`define RECAL_RESET         16'h0000
`define SENS_RESET          16'h0000
`define MODE_RESET          16'h0000

`define FP_HOLD_MULT        16
`define LP_HOLD_MULT        4

`endif

//--- verification/touch_proximity_checker_assertions.sv
// Port-level checker for the proximity and calibration block.
// Sees only the top ports; bound from the bench top file.
module touch_proximity_checker #(
  parameter DW = 16
) (
  input logic          clock,       // Clock
  input logic          resetn,      // Reset, active low
  input logic [7:0]    reg_addr,    // Address
  input logic [15:0]   reg_wdata,   // Write data
  input logic          reg_wr,      // Write strobe
  input logic          reg_rd,      // Read strobe
  input logic [15:0]   reg_rdata,   // Read data
  input logic          conv_valid,  // Result valid
  input logic [DW-1:0] conv_data,   // Result
  input logic          seq_done,    // Sequence done
  input logic          low_power,   // Low power mode
  input logic          int_n,       // Interrupt, active low
  input logic          cal_enabled, // Calibration on
  input logic          proximity    // Proximity
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  logic [3:0] fp_q;
  logic [3:0] lp_q;
  logic [9:0] seqs_q;
  // Hold counts snooped from writes; sequences counted since proximity cleared
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      fp_q   <= 4'h0;
      lp_q   <= 4'h0;
      seqs_q <= 10'h000;
    end else begin
      if (reg_wr && reg_addr == 8'h02) begin
        fp_q <= reg_wdata[7:4];
        lp_q <= reg_wdata[11:8];
      end
      if (proximity)
        seqs_q <= 10'h000;
      else if (seq_done && seqs_q != 10'h3ff)
        seqs_q <= seqs_q + 10'h001;
    end
  end
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not idle");
  prox_freeze_a: assert property (proximity |=> !cal_enabled)
    else $error("calibration on during proximity");
  holdoff_fall_a: assert property ($fell(proximity) |-> !cal_enabled)
    else $error("no hold-off after proximity");
  cal_on_seq_a: assert property ($rose(cal_enabled) |-> $past(seq_done))
    else $error("calibration resumed off a sequence");
  cal_clean_a: assert property ($rose(cal_enabled) |-> !proximity && int_n)
    else $error("calibration resumed while active");
  fp_hold_a: assert property ($rose(cal_enabled) && !low_power |-> seqs_q >= {fp_q, 4'h0})
    else $error("full power hold-off short");
  lp_hold_a: assert property ($rose(cal_enabled) && low_power |-> seqs_q >= {lp_q, 2'b00})
    else $error("low power hold-off short");
  int_on_conv_a: assert property ($changed(int_n) |-> $past(conv_valid))
    else $error("interrupt moved without result");
  prox_on_conv_a: assert property ($rose(proximity) |-> $past(conv_valid) || $past(conv_valid, 2))
    else $error("proximity without result");
  cover property ($rose(proximity));
  cover property ($rose(cal_enabled));
  cover property ($fell(int_n));
endmodule

//--- verification/touch_host_model.sv
// Host model: owns the register bus.
// Assumes one clock and a slave that never stalls.
module touch_host_model (
  input  logic        clock,             // Clock
  output logic [7:0]  reg_addr = 8'h00,  // Address
  output logic [15:0] reg_wdata = 16'h0, // Write data
  output logic        reg_wr = 1'b0,     // Write strobe
  output logic        reg_rd = 1'b0,     // Read strobe
  input  logic [15:0] reg_rdata          // Read data
);
  timeunit 1ns;
  timeprecision 1ps;
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask
  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    @(posedge clock);
    d = reg_rdata;
  endtask
endmodule

//--- verification/test_touch_proximity_calibration.sv
// Bench for the proximity and calibration block.
// Drives results and sequences itself; the host model owns the bus.
`include "touch_proximity_map.vh"
module test_touch_proximity_calibration;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0;
  logic        resetn = 1'b1;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic        conv_valid = 1'b0;
  logic [15:0] conv_data = 16'h0000;
  logic        seq_done = 1'b0;
  logic        low_power = 1'b0;
  logic        int_n;
  logic        cal_enabled;
  logic        proximity;
  int          fails = 0;
  int          cmp_count = 0;
  always #4 clock = ~clock;
  touch_proximity_calibration i_touch_proximity_calibration (.clock, .resetn,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .conv_valid, .conv_data,
    .seq_done, .low_power, .int_n, .cal_enabled, .proximity);
  touch_host_model u_host (.clock, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  function automatic logic [15:0] rmask(input logic [7:0] a);
    case (a)
      `HOLD_SKIP_OFFSET: return 16'h0fff;
      `SENS_OFFSET: return 16'h00ff;
      `LEVEL_OFFSET, `RECAL_OFFSET, `MODE_OFFSET: return 16'hffff;
      default: return 16'h0000;
    endcase
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] v;
    u_host.rd(a, v);
    chk(v, exp);
  endtask
  task automatic conv(input logic [15:0] v);
    @(posedge clock);
    conv_valid <= 1'b1;
    conv_data  <= v;
    @(posedge clock);
    conv_valid <= 1'b0;
    repeat (3) @(posedge clock);
  endtask
  task automatic seqs(input int n);
    repeat (n) begin
      @(posedge clock);
      seq_done <= 1'b1;
      @(posedge clock);
      seq_done <= 1'b0;
    end
  endtask
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clock);
    fails++;
    finish_test();
  end
  initial begin
    logic [7:0]  a;
    logic [15:0] d;
    logic [7:0]  pick [6] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h1f};
    void'($urandom(94033));
    resetn <= 1'b0;
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    for (int i = 2; i < 7; i++) chk_rd(8'(i), 16'h0000);
    chk_rd(`STATUS_OFFSET, 16'h0002);
    $display("reset values done");
    for (int i = 0; i < 40; i++) begin
      a = pick[$urandom_range(0, 5)];
      d = 16'($urandom);
      u_host.wr(a, d);
      chk_rd(a, d & rmask(a));
    end
    $display("register access done");
    u_host.wr(`HOLD_SKIP_OFFSET, 16'h0210);
    u_host.wr(`LEVEL_OFFSET, 16'h3f04);
    u_host.wr(`SENS_OFFSET, 16'h0000);
    u_host.wr(`MODE_OFFSET, 16'h00ff);
    u_host.wr(`RECAL_OFFSET, 16'h0c00);
    repeat (4) conv(16'h000a);
    conv(16'h000e);
    chk({15'h0, proximity}, 16'h0000);
    conv(16'h001e);
    chk({14'h0, proximity, cal_enabled}, 16'h0002);
    repeat (4) conv(16'h001e);
    chk({15'h0, proximity}, 16'h0000);
    seqs(15);
    chk({15'h0, cal_enabled}, 16'h0000);
    seqs(5);
    chk({15'h0, cal_enabled}, 16'h0001);
    $display("full power hold-off done");
    low_power <= 1'b1;
    repeat (4) conv(16'h0200);
    chk({14'h0, proximity, int_n}, 16'h0002);
    seqs(3);
    chk_rd(`AMBIENT_OFFSET, 16'h0200);
    conv(16'h0200);
    chk({14'h0, proximity, int_n}, 16'h0001);
    seqs(7);
    chk({15'h0, cal_enabled}, 16'h0000);
    seqs(5);
    chk({15'h0, cal_enabled}, 16'h0001);
    $display("low power recalibration done");
    finish_test();
  end
endmodule
bind touch_proximity_calibration touch_proximity_checker #(.DW(DW)) i_chk (.clock, .resetn,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .conv_valid, .conv_data,
  .seq_done, .low_power, .int_n, .cal_enabled, .proximity);
